// File: loader_parts.sv
// Shared constants of the serial loader and the identification byte table.
package loader_pkg;
  localparam logic [7:0] START_MARK = 8'h3a;
  localparam logic [7:0] TYPE_DATA = 8'h00;
  localparam logic [7:0] TYPE_END = 8'h01;
  localparam logic [7:0] TYPE_EXT = 8'h02;
  localparam logic [7:0] EXT_LEN = 8'h02;
  localparam logic [7:0] END_LEN = 8'h00;
  localparam logic [15:0] EXT_LIMIT = 16'h1000;
  localparam logic [15:0] PW_AREA_LO = 16'hc000;
  localparam logic [15:0] PW_AREA_HI = 16'hff9f;
  localparam logic [15:0] PW_LIMIT = 16'hffa0;
  localparam logic [15:0] BLANK_LO = 16'hffe0;
  localparam logic [15:0] BLANK_HI = 16'hffff;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [7:0] PW_MIN = 8'h08;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [3:0] ID_LAST = 4'hc;
  localparam logic [2:0] ADDR_LAST = 3'h3;
  localparam logic [7:0] ID_COUNT = 8'h0a;
  localparam logic [7:0] ID_ADDR_LEN = 8'h02;
  localparam logic [7:0] ID_RSV0 = 8'h1d;
  localparam logic [7:0] ID_RSV = 8'h00;
  localparam logic [7:0] ID_BLOCKS = 8'h01;
  localparam logic [15:0] ROM_START = 16'hc000;
  localparam logic [15:0] ROM_END = 16'hffff;

  typedef enum logic [1:0] {
    MODE_WRITE = 2'b00,
    MODE_RAMLOAD = 2'b01,
    MODE_ERASE = 2'b10,
    MODE_ID = 2'b11
  } mode_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00000,
    S_ID_TX = 5'b00001,
    S_BLANK_RD = 5'b00010,
    S_BLANK_CHK = 5'b00011,
    S_ADDR_RX = 5'b00100,
    S_ADDR_CHK = 5'b00101,
    S_CNT_RD = 5'b00110,
    S_CNT_CHK = 5'b00111,
    S_PW_RD = 5'b01000,
    S_PW_RX = 5'b01001,
    S_HEX_WAIT = 5'b01010,
    S_HEX_LEN = 5'b01011,
    S_HEX_AH = 5'b01100,
    S_HEX_AL = 5'b01101,
    S_HEX_TYPE = 5'b01110,
    S_HEX_DATA = 5'b01111,
    S_HEX_SUM = 5'b10000,
    S_SUM_TX = 5'b10001,
    S_HALT = 5'b10010
  } state_t;
endpackage

////////////////////////////////////////////////////////////////////////////
module id_response_rom
  import loader_pkg::*;
(
  input wire logic [3:0] idx,
  output logic [7:0] id_byte
);
  localparam logic [7:0] ID_SUM = 8'(ID_ADDR_LEN + ID_RSV0 + ID_RSV + ID_RSV
    + ID_RSV + ID_BLOCKS + ROM_START[15:8] + ROM_START[7:0] + ROM_END[15:8]
    + ROM_END[7:0]);

  // The last byte makes bytes three through thirteen sum to zero.
  always_comb begin
    case (idx)
      4'h0: id_byte = START_MARK;
      4'h1: id_byte = ID_COUNT;
      4'h2: id_byte = ID_ADDR_LEN;
      4'h3: id_byte = ID_RSV0;
      4'h4: id_byte = ID_RSV;
      4'h5: id_byte = ID_RSV;
      4'h6: id_byte = ID_RSV;
      4'h7: id_byte = ID_BLOCKS;
      4'h8: id_byte = ROM_START[15:8];
      4'h9: id_byte = ROM_START[7:0];
      4'ha: id_byte = ROM_END[15:8];
      4'hb: id_byte = ROM_END[7:0];
      4'hc: id_byte = 8'(ZERO_BYTE - ID_SUM);
      default: id_byte = ZERO_BYTE;
    endcase
  end
endmodule

// File: serial_loader.sv
// Record checker, password verifier and identification sender of the loader.
// How it works
// (R1) After checksum, drop bytes until 3AH.
// (R2) Controller waits for two checksum bytes.
// (R3) Receive or format error halts silently.
// (R4) Record type beyond 00H..02H is error.
// (R5) Bad record checksum is a format error.
// (R6) Extended record length must be 02H.
// (R7) Data after extended address 1000H+ errors.
// (R8) End record length must be 00H.
// (R9) Password addresses stay within C000H..FF9FH.
// (R10) All FFH at FFE0H..FFFFH means blank.
// (R11) Controller always sends both password addresses.
// (R12) Non-blank: length eight, start within limit; code accepts lengths of eight or more.
// (R13) Three equal stored bytes is password error.
// (R14) Mismatching password byte halts silently.
// (R15) Only reset leaves a password halt.
// (R16) Blank write/load takes records right away.
// (R17) Controller sends no password when erasing blank.
// (R18) Count byte, then password bytes in flash.
// (R19) Identification is thirteen bytes in order.
// (R20) Last identification byte is two's complement.
// (R21) Developers should keep one fixed password.
// (R22) Password halt stops link without code.
// (R23) Halted device neither sends nor acts.
module serial_loader
  import loader_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cmd_start,
  input wire logic [1:0] cmd_mode,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_error,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic [15:0] flash_addr,
  input wire logic [7:0] flash_rdata,
  input wire logic [15:0] sum_word,
  output logic rec_valid,
  output logic [15:0] rec_addr,
  output logic [7:0] rec_data,
  output logic blank,
  output logic done,
  output logic halted
);
  typedef struct packed {
    state_t state;
    mode_t mode;
    logic [7:0] cnt;
    logic [7:0] len;
    logic [7:0] rtype;
    logic [7:0] sum;
    logic [15:0] addr;
    logic [15:0] ext;
    logic [15:0] pn;
    logic [15:0] pc;
    logic [7:0] n;
    logic [7:0] prev1;
    logic [7:0] prev2;
    logic blank;
    logic tx_valid;
    logic [7:0] tx_data;
    logic [15:0] flash_addr;
    logic rec_valid;
    logic [15:0] rec_addr;
    logic [7:0] rec_data;
    logic done;
    logic halted;
  } loader_t;

  loader_t s_q;
  loader_t s_d;
  logic [7:0] id_byte;
  logic rx_ok;
  logic [7:0] sum_next;
  default clocking loader_cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  function automatic logic in_pw_area(input logic [15:0] a);
    in_pw_area = (a >= PW_AREA_LO) && (a <= PW_AREA_HI);
  endfunction

  function automatic logic receiving(input state_t st);
    receiving = (st == S_ADDR_RX) || (st == S_PW_RX) || (st == S_HEX_WAIT)
      || (st == S_HEX_LEN) || (st == S_HEX_AH) || (st == S_HEX_AL)
      || (st == S_HEX_TYPE) || (st == S_HEX_DATA) || (st == S_HEX_SUM);
  endfunction

  id_response_rom id_rom (
    .idx(s_q.cnt[3:0]),
    .id_byte(id_byte)
  );

  assign rx_ok = rx_valid && !rx_error;
  assign sum_next = 8'(s_q.sum + rx_data);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.rec_valid = 1'b0;
    s_d.done = 1'b0;
    case (s_q.state)
      S_IDLE: begin
        if (cmd_start) begin
          s_d.mode = mode_t'(cmd_mode);
          s_d.cnt = ZERO_BYTE;
          if (mode_t'(cmd_mode) == MODE_ID) begin
            s_d.state = S_ID_TX;
          end else begin
            s_d.blank = 1'b1;
            s_d.flash_addr = BLANK_LO;
            s_d.state = S_BLANK_RD;
          end
        end
      end
      S_ID_TX: begin
        if (!s_q.tx_valid) begin
          s_d.tx_valid = 1'b1;
          s_d.tx_data = id_byte; // R19 R20
        end else if (tx_ready) begin
          s_d.tx_valid = 1'b0;
          s_d.cnt = 8'(s_q.cnt + ONE_BYTE);
          if (s_q.cnt[3:0] == ID_LAST) begin
            s_d.done = 1'b1;
            s_d.state = S_IDLE;
          end
        end
      end
      S_BLANK_RD: begin
        s_d.state = S_BLANK_CHK;
      end
      S_BLANK_CHK: begin
        if (flash_rdata != ERASED) begin
          s_d.blank = 1'b0; // R10
        end
        if (s_q.flash_addr == BLANK_HI) begin
          s_d.state = S_ADDR_RX;
        end else begin
          s_d.flash_addr = 16'(s_q.flash_addr + 16'h0001);
          s_d.state = S_BLANK_RD;
        end
      end
      S_ADDR_RX: begin
        if (rx_ok) begin
          if (s_q.cnt[1]) begin
            s_d.pc = {s_q.pc[7:0], rx_data};
          end else begin
            s_d.pn = {s_q.pn[7:0], rx_data};
          end
          s_d.cnt = 8'(s_q.cnt + ONE_BYTE);
          if (s_q.cnt[2:0] == ADDR_LAST) begin
            s_d.state = S_ADDR_CHK;
          end
        end
      end
      S_ADDR_CHK: begin
        s_d.cnt = ZERO_BYTE;
        if (!in_pw_area(s_q.pn) || !in_pw_area(s_q.pc)) begin
          s_d.state = S_HALT; // R9
        end else if (s_q.blank) begin
          if (s_q.mode == MODE_ERASE) begin
            s_d.done = 1'b1;
            s_d.state = S_IDLE; // R17
          end else begin
            s_d.state = S_HEX_WAIT; // R16
          end
        end else begin
          s_d.flash_addr = s_q.pn; // R18
          s_d.state = S_CNT_RD;
        end
      end
      S_CNT_RD: begin
        s_d.state = S_CNT_CHK;
      end
      S_CNT_CHK: begin
        s_d.n = flash_rdata; // R18
        if (flash_rdata < PW_MIN
            || s_q.pc > 16'(PW_LIMIT - {8'h00, flash_rdata})) begin
          s_d.state = S_HALT; // R12
        end else begin
          s_d.flash_addr = s_q.pc;
          s_d.state = S_PW_RD;
        end
      end
      S_PW_RD: begin
        s_d.state = S_PW_RX;
      end
      S_PW_RX: begin
        if (rx_ok) begin
          s_d.prev1 = flash_rdata;
          s_d.prev2 = s_q.prev1;
          if (s_q.cnt >= 8'h02 && flash_rdata == s_q.prev1
              && s_q.prev1 == s_q.prev2) begin
            s_d.state = S_HALT; // R13
          end else if (rx_data != flash_rdata) begin
            s_d.state = S_HALT; // R14 R22
          end else if (8'(s_q.cnt + ONE_BYTE) == s_q.n) begin
            if (s_q.mode == MODE_ERASE) begin
              s_d.done = 1'b1;
              s_d.state = S_IDLE;
            end else begin
              s_d.state = S_HEX_WAIT;
            end
          end else begin
            s_d.cnt = 8'(s_q.cnt + ONE_BYTE);
            s_d.flash_addr = 16'(s_q.flash_addr + 16'h0001);
            s_d.state = S_PW_RD;
          end
        end
      end
      S_HEX_WAIT: begin
        if (rx_ok && rx_data == START_MARK) begin
          s_d.sum = ZERO_BYTE;
          s_d.state = S_HEX_LEN; // R1
        end
      end
      S_HEX_LEN: begin
        if (rx_ok) begin
          s_d.len = rx_data;
          s_d.sum = sum_next;
          s_d.state = S_HEX_AH;
        end
      end
      S_HEX_AH: begin
        if (rx_ok) begin
          s_d.addr = {rx_data, s_q.addr[7:0]};
          s_d.sum = sum_next;
          s_d.state = S_HEX_AL;
        end
      end
      S_HEX_AL: begin
        if (rx_ok) begin
          s_d.addr = {s_q.addr[15:8], rx_data};
          s_d.sum = sum_next;
          s_d.state = S_HEX_TYPE;
        end
      end
      S_HEX_TYPE: begin
        if (rx_ok) begin
          s_d.rtype = rx_data;
          s_d.sum = sum_next;
          s_d.cnt = ZERO_BYTE;
          if (rx_data > TYPE_EXT) begin
            s_d.state = S_HALT; // R4
          end else if (rx_data == TYPE_EXT && s_q.len != EXT_LEN) begin
            s_d.state = S_HALT; // R6
          end else if (rx_data == TYPE_END && s_q.len != END_LEN) begin
            s_d.state = S_HALT; // R8
          end else if (rx_data == TYPE_DATA && s_q.ext >= EXT_LIMIT) begin
            s_d.state = S_HALT; // R7
          end else if (s_q.len == ZERO_BYTE) begin
            s_d.state = S_HEX_SUM;
          end else begin
            s_d.state = S_HEX_DATA;
          end
        end
      end
      S_HEX_DATA: begin
        if (rx_ok) begin
          s_d.sum = sum_next;
          if (s_q.rtype == TYPE_EXT) begin
            s_d.ext = {s_q.ext[7:0], rx_data};
          end else begin
            s_d.rec_valid = 1'b1;
            s_d.rec_addr = 16'(s_q.addr + {8'h00, s_q.cnt});
            s_d.rec_data = rx_data;
          end
          s_d.cnt = 8'(s_q.cnt + ONE_BYTE);
          if (8'(s_q.cnt + ONE_BYTE) == s_q.len) begin
            s_d.state = S_HEX_SUM;
          end
        end
      end
      S_HEX_SUM: begin
        if (rx_ok) begin
          s_d.cnt = ZERO_BYTE;
          if (sum_next != ZERO_BYTE) begin
            s_d.state = S_HALT; // R5
          end else if (s_q.rtype == TYPE_END) begin
            s_d.state = S_SUM_TX; // R2
          end else begin
            s_d.state = S_HEX_WAIT; // R1
          end
        end
      end
      S_SUM_TX: begin
        if (!s_q.tx_valid) begin
          s_d.tx_valid = 1'b1;
          s_d.tx_data = s_q.cnt[0] ? sum_word[7:0] : sum_word[15:8]; // R2
        end else if (tx_ready) begin
          s_d.tx_valid = 1'b0;
          s_d.cnt = 8'(s_q.cnt + ONE_BYTE);
          if (s_q.cnt[0]) begin
            s_d.done = 1'b1;
            s_d.state = S_IDLE;
          end
        end
      end
      S_HALT: begin
        s_d.tx_valid = 1'b0; // R22 R23
      end
      default: begin
        s_d.state = S_HALT;
      end
    endcase
    if (rx_valid && rx_error && receiving(s_q.state)) begin
      s_d.state = S_HALT; // R3
      s_d.rec_valid = 1'b0;
    end
    s_d.halted = (s_d.state == S_HALT);
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0; // R15
    end else begin
      s_q <= s_d;
    end
  end

  assign tx_valid = s_q.tx_valid;
  assign tx_data = s_q.tx_data;
  assign flash_addr = s_q.flash_addr;
  assign rec_valid = s_q.rec_valid;
  assign rec_addr = s_q.rec_addr;
  assign rec_data = s_q.rec_data;
  assign blank = s_q.blank;
  assign done = s_q.done;
  assign halted = s_q.halted;

  ////////////////////////////////////////////////////////////////////////////
  halt_sticky_a: assert property (s_q.state == S_HALT // R15
    |=> s_q.state == S_HALT) else $error("halt was left without reset");
  halt_silent_a: assert property (s_q.state == S_HALT // R23
    |=> !tx_valid && !rec_valid && !done)
    else $error("halted device still active");
  rx_error_a: assert property (rx_valid && rx_error // R3
    && receiving(s_q.state) |=> halted ##1 !tx_valid)
    else $error("receive error did not halt silently");
  wait_mark_a: assert property (s_q.state == S_HEX_WAIT && rx_ok // R1
    && rx_data != START_MARK |=> s_q.state == S_HEX_WAIT && !rec_valid)
    else $error("byte other than start mark was taken");
  bad_type_a: assert property (s_q.state == S_HEX_TYPE && rx_ok // R4
    && rx_data > TYPE_EXT |=> halted)
    else $error("unknown record type accepted");
  ext_len_a: assert property (s_q.state == S_HEX_TYPE && rx_ok // R6
    && rx_data == TYPE_EXT && s_q.len != EXT_LEN |=> halted)
    else $error("bad extended record length accepted");
  end_len_a: assert property (s_q.state == S_HEX_TYPE && rx_ok // R8
    && rx_data == TYPE_END && s_q.len != END_LEN |=> halted)
    else $error("bad end record length accepted");
  ext_limit_a: assert property (s_q.state == S_HEX_TYPE && rx_ok // R7
    && rx_data == TYPE_DATA && s_q.ext >= EXT_LIMIT |=> halted)
    else $error("data record beyond address limit accepted");
  sum_check_a: assert property (s_q.state == S_HEX_SUM && rx_ok // R5
    && sum_next != ZERO_BYTE |=> halted)
    else $error("record checksum error accepted");
  pw_short_a: assert property (s_q.state == S_CNT_CHK // R12
    && flash_rdata < PW_MIN |=> halted)
    else $error("short password accepted");
  pw_match_a: assert property (s_q.state == S_PW_RX && rx_ok // R14
    && rx_data != flash_rdata |=> halted)
    else $error("password mismatch accepted");
endmodule

// File: prog_partner.sv
// Model of the far side: flash storage and the byte acceptor of the link.
module prog_partner (
  input wire logic core_clk,
  input wire logic slow,
  input wire logic [15:0] flash_addr,
  output logic [7:0] flash_rdata,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [1:0] pace_q;
  initial begin
    pace_q = 2'h0;
    for (int a = 0; a < 65536; a++) mem[a] = 8'h00;
  end
  // Flash is read synchronously with one cycle of latency.
  always @(posedge core_clk) begin
    flash_rdata <= mem[flash_addr];
    pace_q <= pace_q + 2'h1;
  end
  // Accepts every sent byte at once, or only one cycle in four while slow is set.
  assign tx_ready = !slow || (pace_q == 2'h3);
endmodule

// File: serial_loader_record_password_check_bench.sv
// Self-checking testbench of the serial loader.
module serial_loader_record_password_check_bench import loader_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, reset_n, cmd_start, rx_valid, rx_error, slow;
  logic [1:0] cmd_mode;
  logic [7:0] rx_data, tx_data, rec_data, flash_rdata;
  logic [15:0] sum_word, flash_addr, rec_addr, last_addr;
  logic tx_valid, tx_ready, rec_valid, blank, done, halted;
  int mismatches, cmp_count, done_seen;
  logic [7:0] txq[$];
  logic [7:0] recq[$];
  serial_loader i_serial_loader (.core_clk(core_clk), .reset_n(reset_n),
    .cmd_start(cmd_start), .cmd_mode(cmd_mode), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_error(rx_error), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .flash_addr(flash_addr),
    .flash_rdata(flash_rdata), .sum_word(sum_word), .rec_valid(rec_valid),
    .rec_addr(rec_addr), .rec_data(rec_data), .blank(blank), .done(done),
    .halted(halted));
  prog_partner i_prog_partner (.core_clk(core_clk), .slow(slow),
    .flash_addr(flash_addr), .flash_rdata(flash_rdata),
    .tx_ready(tx_ready));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) txq.push_back(tx_data);
    if (rec_valid === 1'b1) begin
      recq.push_back(rec_data);
      last_addr = rec_addr;
    end
    if (done === 1'b1) done_seen++;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    cyc(2);
    reset_n <= 1'b1;
    cyc(1);
    txq.delete();
    recq.delete();
    done_seen = 0;
  endtask
  task automatic send(input logic [7:0] b);
    rx_valid <= 1'b1;
    rx_data <= b;
    cyc(1);
    rx_valid <= 1'b0;
    cyc(2);
  endtask
  task automatic pulse_cmd(input logic [1:0] m);
    cmd_start <= 1'b1;
    cmd_mode <= m;
    cyc(1);
    cmd_start <= 1'b0;
  endtask
  task automatic start(input logic [1:0] m, input logic [15:0] pn,
                       input logic [15:0] pc);
    pulse_cmd(m);
    cyc(70);
    send(pn[15:8]);
    send(pn[7:0]);
    send(pc[15:8]);
    send(pc[7:0]);
    cyc(3);
  endtask
  task automatic wait_done();
    for (int i = 0; i < 3000 && done_seen == 0; i++) cyc(1);
  endtask
  task automatic flash_setup(input logic is_blank, input logic [7:0] n);
    for (int a = 16'hffe0; a <= 16'hffff; a++)
      i_prog_partner.mem[a] = is_blank ? ERASED : 8'h5a;
    i_prog_partner.mem[16'hf000] = n;
    for (int k = 0; k < 16; k++) begin
      i_prog_partner.mem[16'hf001 + k] = 8'h41 + 8'(k);
    end
  endtask
  task automatic rec(input logic [7:0] f[$], input logic bad);
    logic [7:0] s;
    s = bad ? 8'h01 : 8'h00;
    send(START_MARK);
    foreach (f[i]) begin
      send(f[i]);
      s = s - f[i];
    end
    send(s);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic test_id();
    logic [7:0] e[13];
    e = '{START_MARK, ID_COUNT, ID_ADDR_LEN, ID_RSV0, ID_RSV, ID_RSV, ID_RSV,
          ID_BLOCKS, ROM_START[15:8], ROM_START[7:0], ROM_END[15:8],
          ROM_END[7:0], 8'h00};
    for (int i = 2; i < 12; i++) e[12] = e[12] - e[i];
    do_reset();
    slow <= 1'b1;
    pulse_cmd(MODE_ID);
    wait_done();
    check(16'(txq.size()), 16'd13);
    check(16'(done_seen), 16'h1);
    for (int i = 0; i < 13 && i < txq.size(); i++) check(txq[i], e[i]);
    slow <= 1'b0;
    $display("test id response finished");
  endtask
  task automatic test_blank_write();
    do_reset();
    flash_setup(1'b1, 8'h08);
    sum_word <= 16'h1234;
    start(MODE_WRITE, 16'hf000, 16'hf001);
    send(8'h55);
    rec('{8'h02, 8'hc1, 8'h00, TYPE_DATA, 8'haa, 8'hbb}, 1'b0);
    send(8'h77);
    rec('{EXT_LEN, 8'h00, 8'h00, TYPE_EXT, 8'h0f, 8'hff}, 1'b0);
    rec('{8'h01, 8'hc2, 8'h00, TYPE_DATA, 8'hcc}, 1'b0);
    rec('{END_LEN, 8'h00, 8'h00, TYPE_END}, 1'b0);
    wait_done();
    check(16'(blank), 16'h1);
    check(16'(recq.size()), 16'd3);
    check({recq[0], recq[1]}, 16'haabb);
    check(16'(recq[2]), 16'h00cc);
    check(last_addr, 16'hc200);
    check(16'(txq.size()), 16'd2);
    check({txq[0], txq[1]}, 16'h1234);
    check(16'(halted), 16'h0);
    $display("test blank write finished");
  endtask
  task automatic test_format();
    int nrec;
    for (int c = 0; c < 7; c++) begin
      do_reset();
      flash_setup(1'b1, 8'h08);
      start((c == 6) ? MODE_RAMLOAD : MODE_WRITE, 16'hf000, 16'hf001);
      case (c)
        0: rec('{8'h00, 8'hc0, 8'h00, 8'h03}, 1'b0);
        1: rec('{8'h01, 8'hc0, 8'h00, TYPE_DATA, 8'h11}, 1'b1);
        2: rec('{8'h01, 8'h00, 8'h00, TYPE_EXT, 8'h10}, 1'b0);
        3: begin
          rec('{EXT_LEN, 8'h00, 8'h00, TYPE_EXT, 8'h10, 8'h00}, 1'b0);
          rec('{8'h01, 8'hc0, 8'h00, TYPE_DATA, 8'h11}, 1'b0);
        end
        4: rec('{8'h01, 8'h00, 8'h00, TYPE_END, 8'h00}, 1'b0);
        5: begin
          rx_error <= 1'b1;
          send(START_MARK);
          rx_error <= 1'b0;
        end
        default: begin
          send(START_MARK);
          send(8'h43);
          send(8'h4f);
          send(8'h44);
          send(8'h45);
        end
      endcase
      cyc(4);
      check(16'(halted), 16'h1);
      nrec = recq.size();
      rec('{8'h01, 8'hc0, 8'h00, TYPE_DATA, 8'h22}, 1'b0);
      check(16'(recq.size()), 16'(nrec));
      check(16'(txq.size()), 16'd0);
    end
    $display("test format errors finished");
  endtask
  task automatic test_password();
    logic [15:0] pn, pc;
    logic [7:0] b;
    for (int c = 0; c < 7; c++) begin
      do_reset();
      flash_setup(c == 6, (c == 2) ? 8'h07 : 8'h08);
      pn = (c == 5) ? PW_LIMIT : 16'hf000;
      pc = (c == 3) ? 16'hff99 : 16'hf001;
      if (c == 4) begin
        i_prog_partner.mem[16'hf002] = 8'h41;
        i_prog_partner.mem[16'hf003] = 8'h41;
      end
      if (c == 3) begin
        for (int k = 0; k < 8; k++) begin
          i_prog_partner.mem[16'hff99 + k] = 8'h41 + 8'(k);
        end
      end
      start(MODE_ERASE, pn, pc);
      for (int k = 0; k < 8 && c != 6; k++) begin
        b = 8'h41 + 8'(k);
        if (c == 4 && k < 3) b = 8'h41;
        if (c == 1 && k == 7) b = ~b;
        send(b);
      end
      wait_done();
      check(16'(halted), (c == 0 || c == 6) ? 16'h0 : 16'h1);
      check(16'(done_seen), (c == 0 || c == 6) ? 16'h1 : 16'h0);
      check(16'(txq.size()), 16'd0);
      if (c == 1) begin
        pulse_cmd(MODE_ID);
        cyc(50);
        check(16'(txq.size()), 16'd0);
        do_reset();
        check(16'(halted), 16'h0);
      end
    end
    $display("test password finished");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    cmd_start = 1'b0;
    cmd_mode = 2'b00;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_error = 1'b0;
    slow = 1'b0;
    sum_word = 16'h0000;
    mismatches = 0;
    cmp_count = 0;
    done_seen = 0;
    cyc(20);
    reset_n <= 1'b1;
    cyc(1);
    test_id();
    test_blank_write();
    test_format();
    test_password();
    complete_run();
  end
  initial begin
    cyc(80000);
    mismatches++;
    complete_run();
  end
endmodule
